// ==== hw/rpi_pkg.sv ====
// Package for the signal-strength pulse indicator.
// Assumes a single 100 MHz clock; shared by the top and its tick divider.
`default_nettype none
package rpi_pkg;
    // Clock and timing figures
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PWM_STEP_NS     = 208000;      // 0.208 ms per duty step
    localparam int PWM_STEP_CYC    = PWM_STEP_NS / CLK_PERIOD_NS;
    localparam int PIN_MS_NS       = 1000000;     // Power-up input time unit, 1 ms
    localparam int PIN_MS_CYC      = PIN_MS_NS / CLK_PERIOD_NS;
    localparam int HOLD_UNIT_MS    = 100;         // Hold setting unit, 100 ms
    localparam int HOLD_UNIT_CYC   = HOLD_UNIT_MS * (PIN_MS_NS / CLK_PERIOD_NS);

    // Duty quantisation: 40 steps per 8.32 ms period, 95 percent ceiling
    localparam logic [5:0] PWM_STEPS_PER_PERIOD = 6'h28;   // 40
    localparam logic [5:0] PWM_STEP_LAST        = 6'h27;   // 39
    localparam logic [5:0] PWM_STEPS_MAX        = 6'h26;   // 38 of 40 = 95 %
    localparam logic [5:0] PWM_STEPS_AT_0DB     = 6'h0d;   // 13 steps intercept
    localparam logic [9:0] PWM_DB_MUL           = 10'h003; // 0.6 step per dB = 3/5
    localparam logic [9:0] PWM_DB_DIV           = 10'h005;

    // Command codes
    localparam logic [7:0] CMD_PWM_HOLD     = 8'h22;
    localparam logic [7:0] CMD_SIGNAL_LEVEL = 8'h1c;

    // Hold setting
    localparam logic [7:0] HOLD_RESET     = 8'h00;
    localparam logic [7:0] HOLD_MAX       = 8'h7f;
    localparam logic [7:0] HOLD_PERMANENT = 8'hff;

    // Signal level range
    localparam logic [7:0] LEVEL_MIN   = 8'h06;
    localparam logic [7:0] LEVEL_MAX   = 8'h36;
    localparam logic [7:0] LEVEL_RESET = 8'h06;

    // Pin control sequence
    typedef enum logic [2:0] {
        RPI_PIN_SAMPLE = 3'b001,
        RPI_PIN_INPUT  = 3'b010,
        RPI_PIN_DRIVE  = 3'b100
    } rpi_pin_state_t;
endpackage
`default_nettype wire

// ==== hw/rpi_tick_div.sv ====
// Free-running divider giving a one-cycle enable pulse every DIV clocks.
// Assumes i_clk and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module rpi_tick_div #(
    parameter int DIV = 4
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_clear,
    output logic      o_tick
);
    import rpi_pkg::*;

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_clear) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_clear) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= (count == LAST);
        end
    end
endmodule
`default_nettype wire

// ==== hw/rpi_indicator.sv ====
// Signal-strength pulse indicator on a shared config pin, with its two commands.
// Assumes per-packet margin and level from the receive path on the same clock,
// and a command port already decoded from the host link.
`timescale 1ns/10ps
`default_nettype none

module rpi_indicator #(
    parameter int STEP_CYC = rpi_pkg::PWM_STEP_CYC,
    parameter int MS_CYC   = rpi_pkg::PIN_MS_CYC,
    parameter int HOLD_CYC = rpi_pkg::HOLD_UNIT_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_pkt_valid,
    input  wire logic [7:0] i_pkt_margin_db,
    input  wire logic [7:0] i_pkt_level,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_write,
    input  wire logic [7:0] i_cmd_code,
    input  wire logic [7:0] i_cmd_wdata,
    output logic            o_rsp_valid,
    output logic            o_rsp_error,
    output logic [7:0]      o_rsp_data,
    input  wire logic       i_cfg_pin,
    output logic            o_cfg_pin,
    output logic            o_cfg_oe,
    output logic            o_cmd_mode_entry,
    output logic            o_pwrup_done
);
    import rpi_pkg::*;

    logic [7:0]     signal_pwm_hold_time;
    logic [7:0]     last_packet_signal_level;
    logic [2:0]     pin_sync;
    logic [2:0]     sync_fill;
    rpi_pin_state_t pin_state;
    logic [7:0]     pwrup_ms;
    logic [7:0]     hold_left;
    logic           pwm_active;
    logic [5:0]     pend_steps;
    logic [5:0]     duty_steps;
    logic [5:0]     step_idx;
    logic           step_tick;
    logic           ms_tick;
    logic           hold_tick;
    logic [5:0]     next_steps;
    logic [9:0]     margin_frac;
    logic [7:0]     next_level;
    logic           hold_ok;
    logic           period_end;

    // Step, millisecond and hold-unit timebases
    rpi_tick_div #(.DIV(STEP_CYC)) u_step_div (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (1'b0),
        .o_tick  (step_tick)
    );

    rpi_tick_div #(.DIV(MS_CYC)) u_ms_div (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (1'b0),
        .o_tick  (ms_tick)
    );

    // Hold unit restarts on each packet so the timeout is exact
    rpi_tick_div #(.DIV(HOLD_CYC)) u_hold_div (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (i_pkt_valid),
        .o_tick  (hold_tick)
    );

    // Margin to duty steps: 13 + 3*dB/5, zero at or below sensitivity
    always_comb begin
        margin_frac = (10'(i_pkt_margin_db) * PWM_DB_MUL) / PWM_DB_DIV;
        if (i_pkt_margin_db == 8'h00) begin
            next_steps = 6'h00;
        end else if (margin_frac >= 10'(PWM_STEPS_MAX - PWM_STEPS_AT_0DB)) begin
            next_steps = PWM_STEPS_MAX;
        end else begin
            next_steps = PWM_STEPS_AT_0DB + margin_frac[5:0];
        end
    end

    // Clamp reported level into its legal range
    always_comb begin
        if (i_pkt_level < LEVEL_MIN) begin
            next_level = LEVEL_MIN;
        end else if (i_pkt_level > LEVEL_MAX) begin
            next_level = LEVEL_MAX;
        end else begin
            next_level = i_pkt_level;
        end
    end

    assign hold_ok    = (i_cmd_wdata <= HOLD_MAX) || (i_cmd_wdata == HOLD_PERMANENT);
    assign period_end = step_tick && (step_idx == PWM_STEP_LAST);

    // Hold-time setting
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            signal_pwm_hold_time <= HOLD_RESET;
        end else if (i_cmd_valid && i_cmd_write && i_cmd_code == CMD_PWM_HOLD && hold_ok) begin
            signal_pwm_hold_time <= i_cmd_wdata;
        end
    end

    // Last packet level
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            last_packet_signal_level <= LEVEL_RESET;
        end else if (i_pkt_valid) begin
            last_packet_signal_level <= next_level;
        end
    end

    // Command answers, one byte each
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rsp_valid <= 1'b0;
            o_rsp_error <= 1'b0;
            o_rsp_data  <= 8'h00;
        end else begin
            o_rsp_valid <= i_cmd_valid;
            o_rsp_error <= 1'b0;
            o_rsp_data  <= 8'h00;
            if (i_cmd_valid) begin
                case (i_cmd_code)
                    CMD_PWM_HOLD: begin
                        o_rsp_data  <= i_cmd_write ? 8'h00 : signal_pwm_hold_time;
                        o_rsp_error <= i_cmd_write && !hold_ok;
                    end
                    CMD_SIGNAL_LEVEL: begin
                        o_rsp_data  <= i_cmd_write ? 8'h00 : last_packet_signal_level;
                        o_rsp_error <= i_cmd_write;
                    end
                    default: begin
                        o_rsp_error <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Config pin synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_sync  <= 3'b000;
            sync_fill <= 3'b000;
        end else begin
            pin_sync  <= {pin_sync[1:0], i_cfg_pin};
            // Marks flops that hold a real pin sample, not reset zeros
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    // Milliseconds since power-up, saturating
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pwrup_ms <= 8'h00;
        end else if (ms_tick && pwrup_ms != 8'hff) begin
            pwrup_ms <= pwrup_ms + 8'h01;
        end
    end

    // Pin direction sequence
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_state        <= RPI_PIN_SAMPLE;
            o_cmd_mode_entry <= 1'b0;
            o_pwrup_done     <= 1'b0;
        end else begin
            case (pin_state)
                RPI_PIN_SAMPLE: begin
                    if (sync_fill[2] && (pin_sync[1] == pin_sync[2])) begin
                        o_cmd_mode_entry <= pin_sync[2];
                        o_pwrup_done     <= 1'b1;
                        pin_state        <= RPI_PIN_INPUT;
                    end
                end
                RPI_PIN_INPUT: begin
                    if (signal_pwm_hold_time != HOLD_RESET &&
                        pwrup_ms >= signal_pwm_hold_time) begin
                        pin_state <= RPI_PIN_DRIVE;
                    end
                end
                RPI_PIN_DRIVE: begin
                    if (signal_pwm_hold_time == HOLD_RESET) begin
                        pin_state <= RPI_PIN_INPUT;
                    end
                end
                default: begin
                    pin_state <= RPI_PIN_SAMPLE;
                end
            endcase
        end
    end

    // Hold countdown, restarted per packet
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            hold_left  <= 8'h00;
            pwm_active <= 1'b0;
        end else if (i_pkt_valid && signal_pwm_hold_time != HOLD_RESET) begin
            hold_left  <= signal_pwm_hold_time;
            pwm_active <= 1'b1;
        end else if (signal_pwm_hold_time == HOLD_RESET) begin
            pwm_active <= 1'b0;
        end else if (hold_tick && signal_pwm_hold_time != HOLD_PERMANENT) begin
            if (hold_left <= 8'h01) begin
                hold_left  <= 8'h00;
                pwm_active <= 1'b0;
            end else begin
                hold_left <= hold_left - 8'h01;
            end
        end
    end

    // Pending duty from latest packet
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pend_steps <= 6'h00;
        end else if (i_pkt_valid) begin
            pend_steps <= next_steps;
        end
    end

    // Step position within the period
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            step_idx <= 6'h00;
        end else if (period_end) begin
            step_idx <= 6'h00;
        end else if (step_tick) begin
            step_idx <= step_idx + 6'h01;
        end
    end

    // Duty applied only at period edges
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            duty_steps <= 6'h00;
        end else if (period_end) begin
            duty_steps <= pwm_active ? pend_steps : 6'h00;
        end
    end

    // Pin drive
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_cfg_pin <= 1'b0;
            o_cfg_oe  <= 1'b0;
        end else begin
            o_cfg_oe  <= (pin_state == RPI_PIN_DRIVE);
            o_cfg_pin <= (pin_state == RPI_PIN_DRIVE) && (step_idx < duty_steps);
        end
    end
endmodule
`default_nettype wire

// ==== dv/rpi_indicator_properties.sv ====
// Port checker for the signal-strength pulse indicator.
// Bound into rpi_indicator; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module rpi_indicator_properties
    import rpi_pkg::*;
#(
    parameter int STEP_CYC = 4
) (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_pkt_valid,
    input wire logic [7:0] i_pkt_margin_db,
    input wire logic [7:0] i_pkt_level,
    input wire logic       i_cmd_valid,
    input wire logic       i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic [7:0] i_cmd_wdata,
    input wire logic       o_rsp_valid,
    input wire logic       o_rsp_error,
    input wire logic [7:0] o_rsp_data,
    input wire logic       i_cfg_pin,
    input wire logic       o_cfg_pin,
    input wire logic       o_cfg_oe,
    input wire logic       o_cmd_mode_entry,
    input wire logic       o_pwrup_done
);
    localparam int PER = 40 * STEP_CYC;
    int   hi_cnt;
    int   gap;
    logic seen;
    logic pin_q;
    wire  drv = o_cfg_pin & o_cfg_oe;
    wire  rise = drv & ~pin_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // High-time and rise-to-rise counters
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_q  <= 1'b0;
            hi_cnt <= 0;
            gap    <= 0;
            seen   <= 1'b0;
        end else begin
            pin_q  <= drv;
            hi_cnt <= drv ? hi_cnt + 1 : 0;
            gap    <= rise ? 1 : gap + 1;
            seen   <= seen | rise;
        end
    end
    a_rsp_follows_cmd: assert property (i_cmd_valid |=> o_rsp_valid)
        else $error("command not answered");
    a_rsp_needs_cmd: assert property (o_rsp_valid |-> $past(i_cmd_valid))
        else $error("answer without command");
    a_level_no_write: assert property (i_cmd_valid && i_cmd_write
        && i_cmd_code == CMD_SIGNAL_LEVEL |=> o_rsp_error) else $error("level write taken");
    a_hold_range_err: assert property (i_cmd_valid && i_cmd_write && i_cmd_code == CMD_PWM_HOLD
        && i_cmd_wdata > HOLD_MAX && i_cmd_wdata != HOLD_PERMANENT |=> o_rsp_error)
        else $error("bad hold accepted");
    a_level_in_range: assert property (i_cmd_valid && !i_cmd_write
        && i_cmd_code == CMD_SIGNAL_LEVEL |=> !o_rsp_error
        && o_rsp_data >= LEVEL_MIN && o_rsp_data <= LEVEL_MAX) else $error("level out of range");
    a_reset_quiet: assert property ($rose(i_rst_b) |-> !o_cfg_oe && !o_cfg_pin)
        else $error("pin active after reset");
    a_input_at_pwrup: assert property (!o_pwrup_done |-> !o_cfg_oe)
        else $error("pin driven before sample");
    a_pulse_max: assert property (drv |-> hi_cnt < 38 * STEP_CYC)
        else $error("high time above ceiling");
    a_period_fixed: assert property (rise && seen |-> gap % PER == 0)
        else $error("period broken");
    a_err_no_data: assert property (o_rsp_valid && o_rsp_error |-> o_rsp_data == 8'h00)
        else $error("data on error");
    a_hold_zero_off: assert property (i_cmd_valid && i_cmd_write && i_cmd_code == CMD_PWM_HOLD
        && i_cmd_wdata == 8'h00 |-> ##[1:3] !o_cfg_oe) else $error("pin still driven");
    c_pulse: cover property (rise && seen);
    c_drive: cover property ($rose(o_cfg_oe));
    c_hold_write: cover property (i_cmd_valid && i_cmd_write && i_cmd_code == CMD_PWM_HOLD);
endmodule
bind rpi_indicator rpi_indicator_properties #(.STEP_CYC(STEP_CYC)) u_props (
    .i_clk            (i_clk),
    .i_rst_b          (i_rst_b),
    .i_pkt_valid      (i_pkt_valid),
    .i_pkt_margin_db  (i_pkt_margin_db),
    .i_pkt_level      (i_pkt_level),
    .i_cmd_valid      (i_cmd_valid),
    .i_cmd_write      (i_cmd_write),
    .i_cmd_code       (i_cmd_code),
    .i_cmd_wdata      (i_cmd_wdata),
    .o_rsp_valid      (o_rsp_valid),
    .o_rsp_error      (o_rsp_error),
    .o_rsp_data       (o_rsp_data),
    .i_cfg_pin        (i_cfg_pin),
    .o_cfg_pin        (o_cfg_pin),
    .o_cfg_oe         (o_cfg_oe),
    .o_cmd_mode_entry (o_cmd_mode_entry),
    .o_pwrup_done     (o_pwrup_done)
);
`default_nettype wire

// ==== dv/rpi_meter_model.sv ====
// Meter on the shared pin: straps it while it is an input, counts high time.
// Sees the device's drive and enable; bench clears and reads the count.
`timescale 1ns/10ps
`default_nettype none
module rpi_meter_model (
    input  wire logic   i_clk,
    input  wire logic   i_strap,
    input  wire logic   i_pin_out,
    input  wire logic   i_pin_oe,
    input  wire logic   i_clear,
    output logic        o_pin,
    output logic [15:0] o_high_cnt
);
    assign o_pin = i_pin_oe ? i_pin_out : i_strap;
    always_ff @(posedge i_clk) begin
        if (i_clear) begin
            o_high_cnt <= 16'h0000;
        end else if (o_pin && i_pin_oe) begin
            o_high_cnt <= o_high_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== dv/rpi_indicator_tb.sv ====
// Self-checking bench for rpi_indicator with the meter model on its pin.
// Shortened counts: step 4, ms 8, hold unit 50 cycles.
`timescale 1ns/10ps
`default_nettype none
module rpi_indicator_tb;
    import rpi_pkg::*;
    localparam int STEP = 4;
    localparam int PER  = 40 * STEP;
    typedef struct {logic [7:0] mg; logic [7:0] lv; logic [5:0] st; logic [7:0] el;} rpi_row_t;
    rpi_row_t    rows [6] = '{'{8'h00, 8'h06, 6'h00, 8'h06}, '{8'h0a, 8'h20, 6'h13, 8'h20},
        '{8'h14, 8'h30, 6'h19, 8'h30}, '{8'h1e, 8'h36, 6'h1f, 8'h36},
        '{8'h02, 8'h03, 6'h0e, 8'h06}, '{8'hff, 8'h40, 6'h26, 8'h36}};
    logic        clk, rst_b, pkt_valid, cmd_valid, cmd_write, strap, clear;
    logic [7:0]  margin, level, code, wdata, rsp_data;
    logic        rsp_valid, rsp_error, pin, pin_out, oe, mode, done;
    logic [15:0] hcnt;
    int          err_total, samples_checked, cycles;
    rpi_indicator #(.STEP_CYC(STEP), .MS_CYC(8), .HOLD_CYC(50)) dut (.i_clk(clk),
        .i_rst_b(rst_b), .i_pkt_valid(pkt_valid), .i_pkt_margin_db(margin), .i_pkt_level(level),
        .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_code(code), .i_cmd_wdata(wdata),
        .o_rsp_valid(rsp_valid), .o_rsp_error(rsp_error), .o_rsp_data(rsp_data), .i_cfg_pin(pin),
        .o_cfg_pin(pin_out), .o_cfg_oe(oe), .o_cmd_mode_entry(mode), .o_pwrup_done(done));
    rpi_meter_model u_meter (.i_clk(clk), .i_strap(strap), .i_pin_out(pin_out), .i_pin_oe(oe),
        .i_clear(clear), .o_pin(pin), .o_high_cnt(hcnt));
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Drives one command; answer checked one cycle later, valid left high
    task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d,
                       input logic e, input logic [7:0] x);
        cmd_valid = 1'b1;
        cmd_write = w;
        code = c;
        wdata = d;
        @(negedge clk);
        chk({rsp_valid, rsp_error, 6'h00, rsp_data}, {1'b1, e, 6'h00, x});
    endtask
    task automatic pkt(input logic [7:0] m, input logic [7:0] l);
        pkt_valid = 1'b1;
        margin = m;
        level = l;
        @(negedge clk);
        pkt_valid = 1'b0;
    endtask
    // High cycles over exactly one period
    task automatic duty(input int n);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (PER) @(negedge clk);
        chk(hcnt, 16'(n * STEP));
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_b, pkt_valid, cmd_valid, cmd_write, clear} = 5'h00;
        {margin, level, code, wdata} = 32'h00000000;
        strap = 1'b1;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        cmd(1'b1, CMD_PWM_HOLD, 8'h05, 1'b0, 8'h00);
        cmd_valid = 1'b0;
        repeat (20) @(negedge clk);
        chk(16'({done, mode, oe}), 16'h0006);
        repeat (30) @(negedge clk);
        chk(16'({oe, pin_out}), 16'h0002);
        cmd(1'b0, CMD_PWM_HOLD, 8'h00, 1'b0, 8'h05);
        cmd(1'b1, CMD_PWM_HOLD, 8'h80, 1'b1, 8'h00);
        cmd(1'b1, CMD_PWM_HOLD, 8'hfe, 1'b1, 8'h00);
        cmd(1'b0, CMD_PWM_HOLD, 8'h00, 1'b0, 8'h05);
        cmd(1'b1, CMD_SIGNAL_LEVEL, 8'h10, 1'b1, 8'h00);
        cmd(1'b0, CMD_SIGNAL_LEVEL, 8'h00, 1'b0, 8'h06);
        cmd(1'b1, 8'h33, 8'h00, 1'b1, 8'h00);
        cmd(1'b1, CMD_PWM_HOLD, 8'hff, 1'b0, 8'h00);
        cmd(1'b0, CMD_PWM_HOLD, 8'h00, 1'b0, 8'hff);
        cmd_valid = 1'b0;
        foreach (rows[i]) begin
            pkt(rows[i].mg, rows[i].lv);
            repeat (2 * PER) @(negedge clk);
            duty(int'(rows[i].st));
            cmd(1'b0, CMD_SIGNAL_LEVEL, 8'h00, 1'b0, rows[i].el);
            cmd_valid = 1'b0;
        end
        cmd(1'b1, CMD_PWM_HOLD, 8'h07, 1'b0, 8'h00);
        cmd_valid = 1'b0;
        pkt(8'h14, 8'h30);
        repeat (170) @(negedge clk);
        duty(25);
        repeat (400) @(negedge clk);
        duty(0);
        pkt(8'h1e, 8'h30);
        repeat (300) @(negedge clk);
        pkt(8'h1e, 8'h30);
        repeat (169) @(negedge clk);
        duty(31);
        rst_b = 1'b0;
        strap = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'({oe, pin_out}), 16'h0000);
        rst_b = 1'b1;
        cmd(1'b0, CMD_PWM_HOLD, 8'h00, 1'b0, 8'h00);
        cmd(1'b0, CMD_SIGNAL_LEVEL, 8'h00, 1'b0, 8'h06);
        cmd_valid = 1'b0;
        repeat (60) @(negedge clk);
        chk(16'({done, mode, oe}), 16'h0004);
        cmd(1'b1, CMD_PWM_HOLD, 8'h01, 1'b0, 8'h00);
        cmd_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({oe, pin_out}), 16'h0002);
        // Clearing the hold while driving hands the pin back
        cmd(1'b1, CMD_PWM_HOLD, 8'h00, 1'b0, 8'h00);
        cmd_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({oe, pin_out}), 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
